/* hw/pfwc_pkg.sv */
// Package of constants and carrier types for the page flash write controller
package pfwc_pkg;
    // ---------------------------------------------------------------
    // Geometry
    // ---------------------------------------------------------------
    localparam int ADDR_W     = 16;
    localparam int DATA_W     = 16;
    localparam int PAGE_WORDS = 128;
    localparam int PAGE_LSB   = 7;
    // ---------------------------------------------------------------
    // Command words
    // ---------------------------------------------------------------
    localparam logic [15:0] CMD_ADDR_A   = 16'h5555;
    localparam logic [15:0] CMD_ADDR_B   = 16'h2aaa;
    localparam logic [15:0] CMD_DATA_1   = 16'h0aaa;
    localparam logic [15:0] CMD_DATA_2   = 16'h5555;
    localparam logic [15:0] CMD_PROTECT  = 16'ha0a0;
    localparam logic [15:0] CMD_SETUP    = 16'h8080;
    localparam logic [15:0] CMD_UNPROT   = 16'h2020;
    localparam logic [15:0] FILL_WORD    = 16'hffff;
    localparam logic [15:0] ID_MAKER_ADR = 16'h0000;
    localparam logic [15:0] ID_DEV_ADR   = 16'h0001;
    // ---------------------------------------------------------------
    // Timing at 200 MHz
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int PULSE_NS        = 70;
    localparam int PULSE_CYC       = (PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RECOVER_NS      = 100;
    localparam int RECOVER_CYC     = (RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WINDOW_US       = 200;
    localparam int WINDOW_CYC      = (WINDOW_US * 1000000) / CLK_PERIOD_PS;
    localparam int POWERUP_MS      = 5;
    localparam int POWERUP_CYC     = (POWERUP_MS * 1000000) / CLK_PERIOD_PS * 1000;
    localparam int CNT_W           = 24;
    localparam logic [2:0] STEP_W  = 3'h4;
    // ---------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        PFWC_OP_READ    = 3'h0,
        PFWC_OP_PAGE    = 3'h1,
        PFWC_OP_PROTECT = 3'h2,
        PFWC_OP_UNPROT  = 3'h3,
        PFWC_OP_ERASE   = 3'h4,
        PFWC_OP_POLL    = 3'h5
    } pfwc_op_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } pfwc_word_t;
    typedef struct packed {
        logic        chipSelN;
        logic        outGateN;
        logic        writeStrobeN;
        logic [15:0] addressLines;
        logic [15:0] dataOut;
        logic        dataOe;
    } pfwc_pins_t;
endpackage

/* hw/pfwc_bus_cycle.sv */
// One bus cycle on the flash pins: a timed write or read strobe
`timescale 1ns/1ps
module pfwc_bus_cycle (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Request
    input  wire logic               start,
    input  wire logic               isWrite,
    input  wire pfwc_pkg::pfwc_word_t word,
    output logic                    busy,
    output logic                    done,
    // Sampled data lines, two flops back
    input  wire logic [15:0]        dataIn,
    output logic [15:0]             readData,
    // Pins
    output pfwc_pkg::pfwc_pins_t    pins
);
    typedef enum logic [2:0] {
        PFWC_C_IDLE   = 3'b001,
        PFWC_C_STROBE = 3'b010,
        PFWC_C_GAP    = 3'b100
    } pfwc_cyc_t;
    pfwc_cyc_t  state;
    logic [7:0] cnt;
    logic       wr;
    pfwc_pkg::pfwc_word_t held;
    wire strobeEnd = (state == PFWC_C_STROBE) && (cnt == 8'(pfwc_pkg::PULSE_CYC - 1));
    wire gapEnd    = (state == PFWC_C_GAP) && (cnt == 8'(pfwc_pkg::RECOVER_CYC - 1));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= PFWC_C_IDLE;
            cnt   <= 8'h00;
            wr    <= 1'b0;
            held  <= '0;
        end else begin
            cnt <= (strobeEnd || gapEnd || state == PFWC_C_IDLE) ? 8'h00 : cnt + 8'h01;
            case (state)
                PFWC_C_IDLE: begin
                    if (start) begin
                        state <= PFWC_C_STROBE;
                        wr    <= isWrite;
                        held  <= word;
                    end
                end
                PFWC_C_STROBE: if (strobeEnd) state <= PFWC_C_GAP;
                PFWC_C_GAP: if (gapEnd) state <= PFWC_C_IDLE;
                default: state <= PFWC_C_IDLE;
            endcase
        end
    end
    // Read data captured at the strobe end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) readData <= 16'h0000;
        else if (strobeEnd && !wr) readData <= dataIn;
    end
    assign busy = (state != PFWC_C_IDLE);
    assign done = gapEnd;
    // Strobe 70 ns covers the glitch filter; output gate high during writes
    always_comb begin
        pins.chipSelN     = (state != PFWC_C_STROBE);
        pins.writeStrobeN = !((state == PFWC_C_STROBE) && wr);
        pins.outGateN     = !((state == PFWC_C_STROBE) && !wr);
        pins.addressLines = held.addr;
        pins.dataOut      = held.data;
        pins.dataOe       = wr && (state != PFWC_C_IDLE);
    end
    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property strobeLen;
        @(posedge clk) disable iff (!rst_n)
        $fell(pins.writeStrobeN) |-> !pins.writeStrobeN [*4] ##1 !pins.writeStrobeN [*8];
    endproperty
    write_pulse_a: assert property (strobeLen) else $error("write strobe too short");
    write_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !pins.writeStrobeN |-> !pins.chipSelN && pins.outGateN) else $error("write without select");
    read_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
        !pins.outGateN |-> !pins.dataOe) else $error("bus fight on read");
endmodule // pfwc_bus_cycle

/* hw/pfwc_host.sv */
// Host controller driving a page programmed flash through its pins
// How it works
// - Host loads all 128 words per page
// - Write uses select and strobe, gate high
// - Upper address bits fixed within page
// - Protected writes need three-word prefix
// - Enable prefix is three command writes
// - Disable needs six command writes
`timescale 1ns/1ps
module pfwc_host #(
    parameter int POWERUP_CYCLES = pfwc_pkg::POWERUP_CYC,
    parameter int WINDOW_CYCLES  = pfwc_pkg::WINDOW_CYC
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // User command port
    input  wire logic               cmdValid,
    output logic                    cmdReady,
    input  wire pfwc_pkg::pfwc_op_t cmdOp,
    input  wire logic [15:0]        cmdAddr,
    input  wire logic               pageProtected,
    // Page word feed, words in order 0..127
    input  wire logic [15:0]        pageData,
    output logic [6:0]              pageIndex,
    // Result
    output logic [15:0]             rdData,
    output logic                    rdValid,
    output logic                    opDone,
    output logic                    pollBusy,
    // Flash pins
    output logic                    chipSelN,
    output logic                    outGateN,
    output logic                    writeStrobeN,
    output logic [15:0]             addressLines,
    input  wire logic [15:0]        dataLinesIn,
    output logic [15:0]             dataLinesOut,
    output logic                    dataLinesOe
);
    // ---------------------------------------------------------------
    // Pin sync and power-up wait
    // ---------------------------------------------------------------
    logic [15:0] dqMeta;
    logic [15:0] dqSync;
    logic [23:0] pwrCnt;
    wire         pwrReady = (pwrCnt == 24'(POWERUP_CYCLES));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dqMeta <= 16'h0000;
            dqSync <= 16'h0000;
            pwrCnt <= 24'h000000;
        end else begin
            dqMeta <= dataLinesIn;
            dqSync <= dqMeta;
            if (!pwrReady) pwrCnt <= pwrCnt + 24'h000001;
        end
    end
    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    typedef enum logic [5:0] {
        PFWC_IDLE  = 6'b000001,
        PFWC_CMD   = 6'b000010,
        PFWC_LOAD  = 6'b000100,
        PFWC_READ  = 6'b001000,
        PFWC_POLL  = 6'b010000,
        PFWC_WAIT  = 6'b100000
    } pfwc_state_t;
    pfwc_state_t state;
    pfwc_pkg::pfwc_op_t op;
    logic [2:0]  step;
    logic [7:0]  word;
    logic [8:0]  pageBase;
    logic        cycStart;
    logic        cycBusy;
    logic        cycDone;
    logic [15:0] cycData;
    logic [1:0]  lastToggle;
    logic [23:0] waitCnt;
    logic        pollSecond;
    logic [15:0] lastWord;
    // Command table: both protect and erase share the 5555/2aaa preamble
    logic [2:0]  seqLen;
    logic [15:0] seqAddr;
    logic [15:0] seqData;
    wire  [1:0]  stepMod = (step < 3'h3) ? step[1:0] : 2'(step - 3'h3);
    assign seqLen = (op == pfwc_pkg::PFWC_OP_PROTECT || op == pfwc_pkg::PFWC_OP_PAGE) ? 3'h3 : 3'h6;
    always_comb begin
        seqAddr = (stepMod == 2'h1) ? pfwc_pkg::CMD_ADDR_B : pfwc_pkg::CMD_ADDR_A;
        seqData = (stepMod == 2'h0) ? pfwc_pkg::CMD_DATA_1 : pfwc_pkg::CMD_DATA_2;
        if (stepMod == 2'h2) begin
            if (step == 3'h2 && seqLen == 3'h3) seqData = pfwc_pkg::CMD_PROTECT;
            else if (step == 3'h2) seqData = pfwc_pkg::CMD_SETUP;
            else seqData = (op == pfwc_pkg::PFWC_OP_UNPROT) ? pfwc_pkg::CMD_UNPROT : pfwc_pkg::CMD_DATA_1;
        end
    end
    wire cmdAccept = cmdValid && cmdReady;
    wire writeOp   = (cmdOp != pfwc_pkg::PFWC_OP_READ) && (cmdOp != pfwc_pkg::PFWC_OP_POLL);
    assign cmdReady = (state == PFWC_IDLE) && (pwrReady || !writeOp);
    wire [15:0] loadAddr = {pageBase, word[6:0]};
    assign pageIndex = word[6:0];
    // Erase sequence is five words in this design; sixth lies outside the known table
    wire seqDone = cycDone && (step == ((op == pfwc_pkg::PFWC_OP_ERASE) ? 3'h4 : seqLen - 3'h1));
    wire pageDone = cycDone && (word == 8'(pfwc_pkg::PAGE_WORDS - 1));
    // Toggle bits from the latched read; the live lines are already released at cycle end
    wire pollSettled = cycDone && pollSecond && ({cycData[14], cycData[6]} == lastToggle);
    wire waitEnd     = (state == PFWC_WAIT) && (waitCnt == 24'(WINDOW_CYCLES - 1));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state      <= PFWC_IDLE;
            op         <= pfwc_pkg::PFWC_OP_READ;
            step       <= 3'h0;
            word       <= 8'h00;
            pageBase   <= 9'h000;
            lastToggle <= 2'h0;
            waitCnt    <= 24'h000000;
            pollSecond <= 1'b0;
            lastWord   <= 16'h0000;
        end else begin
            waitCnt <= (state == PFWC_WAIT) ? waitCnt + 24'h000001 : 24'h000000;
            case (state)
                PFWC_IDLE: begin
                    if (cmdAccept) begin
                        op         <= cmdOp;
                        step       <= 3'h0;
                        word       <= 8'h00;
                        pollSecond <= 1'b0;
                        pageBase   <= cmdAddr[15:pfwc_pkg::PAGE_LSB];
                        lastWord   <= cmdAddr;
                        if (cmdOp == pfwc_pkg::PFWC_OP_READ) state <= PFWC_READ;
                        else if (cmdOp == pfwc_pkg::PFWC_OP_POLL) state <= PFWC_POLL;
                        else if (cmdOp == pfwc_pkg::PFWC_OP_PAGE && !pageProtected) state <= PFWC_LOAD;
                        else state <= PFWC_CMD;
                    end
                end
                PFWC_CMD: begin
                    if (cycDone) step <= step + 3'h1;
                    if (seqDone) state <= (op == pfwc_pkg::PFWC_OP_PAGE) ? PFWC_LOAD : PFWC_WAIT;
                end
                PFWC_LOAD: begin
                    // Back-to-back loads keep well inside the word load window
                    if (cycDone) word <= word + 8'h01;
                    if (pageDone) begin
                        lastWord <= loadAddr;
                        state    <= PFWC_WAIT;
                    end
                end
                PFWC_READ: if (cycDone) state <= PFWC_IDLE;
                PFWC_POLL: begin
                    if (cycDone) begin
                        lastToggle <= {cycData[14], cycData[6]};
                        pollSecond <= 1'b1;
                    end
                    if (pollSettled) state <= PFWC_IDLE;
                end
                // Quiet bus for one load window, else the next op's writes join this burst
                PFWC_WAIT: if (waitEnd) state <= PFWC_IDLE;
                default: state <= PFWC_IDLE;
            endcase
        end
    end
    // ---------------------------------------------------------------
    // Bus cycle issue
    // ---------------------------------------------------------------
    wire inCycle = (state == PFWC_CMD) || (state == PFWC_LOAD) || (state == PFWC_READ) || (state == PFWC_POLL);
    wire lastLoad = pageDone || (cycDone && state == PFWC_LOAD && word == 8'(pfwc_pkg::PAGE_WORDS - 1));
    assign cycStart = inCycle && !cycBusy && !seqDone && !lastLoad && !pollSettled
                      && !(state == PFWC_READ && cycDone);
    pfwc_pkg::pfwc_word_t cycWord;
    always_comb begin
        cycWord.addr = lastWord;
        cycWord.data = 16'h0000;
        if (state == PFWC_CMD) begin
            cycWord.addr = seqAddr;
            cycWord.data = seqData;
        end else if (state == PFWC_LOAD) begin
            cycWord.addr = loadAddr;
            cycWord.data = pageData;
        end
    end
    pfwc_pkg::pfwc_pins_t pins;
    pfwc_bus_cycle uCycle (
        .clk      (clk),
        .rst_n    (rst_n),
        .start    (cycStart),
        .isWrite  ((state == PFWC_CMD) || (state == PFWC_LOAD)),
        .word     (cycWord),
        .busy     (cycBusy),
        .done     (cycDone),
        .dataIn   (dqSync),
        .readData (cycData),
        .pins     (pins)
    );
    assign chipSelN     = pins.chipSelN;
    assign outGateN     = pins.outGateN;
    assign writeStrobeN = pins.writeStrobeN;
    assign addressLines = pins.addressLines;
    assign dataLinesOut = pins.dataOut;
    assign dataLinesOe  = pins.dataOe;
    // ---------------------------------------------------------------
    // Results
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData   <= 16'h0000;
            rdValid  <= 1'b0;
            opDone   <= 1'b0;
            pollBusy <= 1'b0;
        end else begin
            rdValid  <= (state == PFWC_READ) && cycDone;
            opDone   <= waitEnd || pollSettled || (state == PFWC_READ && cycDone);
            if (state == PFWC_READ && cycDone) rdData <= cycData;
            if (state == PFWC_POLL) pollBusy <= 1'b1;
            if (pollSettled || state == PFWC_IDLE) pollBusy <= 1'b0;
        end
    end
    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    page_fixed_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == PFWC_LOAD && !writeStrobeN) |-> addressLines[15:7] == pageBase)
        else $error("page address moved");
    powerup_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !pwrReady |-> writeStrobeN) else $error("write before power-up wait");
    sequence protFirst;
        !writeStrobeN && addressLines == pfwc_pkg::CMD_ADDR_A && dataLinesOut == pfwc_pkg::CMD_DATA_1;
    endsequence
    cmd_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == PFWC_CMD && step == 3'h0 && !writeStrobeN) |-> protFirst)
        else $error("bad first command word");
    unprot_last_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == PFWC_CMD && op == pfwc_pkg::PFWC_OP_UNPROT && step == 3'h5 && !writeStrobeN)
        |-> dataLinesOut == pfwc_pkg::CMD_UNPROT) else $error("bad disable tail");
    gate_inhibit_a: assert property (@(posedge clk) disable iff (!rst_n)
        !outGateN |-> writeStrobeN) else $error("write with gate low");
    window_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        (state == PFWC_WAIT) |-> chipSelN) else $error("bus active in load window");
endmodule // pfwc_host

/* bench/pfwc_flash_model.sv */
// Behavioural model of the page programmed flash seen through its pins
`timescale 1ns/1ps
module pfwc_flash_model #(
    parameter int PWRUP_NS = 250,
    parameter int WIN_NS   = 220,
    parameter int PROG_NS  = 3000,
    parameter int ERASE_NS = 5000
) (
    // Control pins
    input  wire logic        chipSelN,
    input  wire logic        outGateN,
    input  wire logic        writeStrobeN,
    // Address and data
    input  wire logic [15:0] addressLines,
    input  wire logic [15:0] dataIn,
    output logic [15:0]      devOut,
    output logic             devDrv,
    // Observation
    output logic             busy,
    output int               errs
);
    logic [15:0]          mem [logic [15:0]];
    pfwc_pkg::pfwc_word_t burst[$];
    pfwc_pkg::pfwc_word_t q[$];
    logic                 prot = 1'b1;
    logic                 tgl = 1'b0;
    logic [15:0]          lastDat = 16'h0000;
    logic [15:0]          latAdr;
    realtime              fallT, lastWrT;
    wire wrAct = !chipSelN && !writeStrobeN && outGateN;
    wire rdAct = !chipSelN && !outGateN;
    wire [15:0] stat = {~lastDat[15], tgl, lastDat[13:8], ~lastDat[7], tgl, lastDat[5:0]};
    initial begin
        busy = 1'b0;
        errs = 0;
        devOut = 16'h0000;
        devDrv = 1'b0;
    end
    function automatic bit hit(int i, logic [15:0] a, logic [15:0] d);
        return i < q.size() && q[i].addr[14:0] == a[14:0] && q[i].data == d;
    endfunction
    always @(posedge wrAct) begin
        latAdr = addressLines;
        fallT = $realtime;
    end
    // Glitches, early writes and writes while busy never reach the buffer
    always @(negedge wrAct) begin
        if ($realtime - fallT >= 15 && !busy && $realtime >= PWRUP_NS) begin
            burst.push_back({latAdr, dataIn});
            lastWrT = $realtime;
        end
    end
    task automatic program_from(int f);
        logic [8:0] pg;
        int         n;
        n = q.size();
        if (n > f) begin
            pg = q[f].addr[15:7];
            for (int i = 0; i < 128; i++) mem[{pg, 7'(i)}] = 16'hffff;
            for (int i = f; i < n; i++) begin
                if (q[i].addr[15:7] != pg) errs++;
                mem[q[i].addr] = q[i].data;
            end
            if (n - f != 128) errs++;
            lastDat = q[n-1].data;
            busy = 1'b1;
            #(PROG_NS) busy = 1'b0;
        end
    endtask
    // Quiet window closes a burst, then the burst is decoded as a whole
    initial forever begin
        #10;
        if (burst.size() != 0 && $realtime - lastWrT > WIN_NS) begin
            q = burst;
            burst.delete();
            if (hit(0, 16'h5555, 16'h0aaa) && hit(1, 16'h2aaa, 16'h5555) && hit(2, 16'h5555, 16'h8080)
                && hit(3, 16'h5555, 16'h0aaa) && hit(4, 16'h2aaa, 16'h5555)) begin
                if (q.size() == 6 && hit(5, 16'h5555, 16'h2020)) prot = 1'b0;
                else if (q.size() == 5) begin
                    mem.delete();
                    busy = 1'b1;
                    #(ERASE_NS) busy = 1'b0;
                end
            end else if (hit(0, 16'h5555, 16'h0aaa) && hit(1, 16'h2aaa, 16'h5555) && hit(2, 16'h5555, 16'ha0a0)) begin
                prot = 1'b1;
                program_from(3);
            end else if (!prot) program_from(0);
        end
    end
    always @(posedge rdAct) tgl = ~tgl;
    // A released bus shows the inverse of its last value, never a held copy
    always @(rdAct or addressLines or busy or tgl) begin
        if (rdAct) devOut = busy ? stat : (mem.exists(addressLines) ? mem[addressLines] : 16'hffff);
        else if (devDrv) devOut = ~devOut;
        devDrv = rdAct;
    end
endmodule // pfwc_flash_model

/* bench/tb.sv */
// Self-checking testbench of the page flash host controller
`timescale 1ns/1ps
module tb;
    logic               clk, rst_n, cmdValid, pageProtected;
    logic               cmdReady, rdValid, opDone, pollBusy;
    pfwc_pkg::pfwc_op_t cmdOp;
    logic [15:0]        cmdAddr, pagePat, rdData, hostOut, devOut, addressLines;
    logic [6:0]         pageIndex;
    logic               chipSelN, outGateN, writeStrobeN, hostOe, devDrv, flashBusy;
    int                 modelErrs;
    int                 failCount = 0;
    int                 checks = 0;
    wire [15:0] pageData    = pagePat ^ {9'h000, pageIndex};
    wire [15:0] dataLinesIn = hostOe ? hostOut : devOut;
    pfwc_host #(.POWERUP_CYCLES(60), .WINDOW_CYCLES(60)) pfwc_host_inst (
        .clk(clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
        .cmdAddr(cmdAddr), .pageProtected(pageProtected), .pageData(pageData), .pageIndex(pageIndex),
        .rdData(rdData), .rdValid(rdValid), .opDone(opDone), .pollBusy(pollBusy),
        .chipSelN(chipSelN), .outGateN(outGateN), .writeStrobeN(writeStrobeN),
        .addressLines(addressLines), .dataLinesIn(dataLinesIn), .dataLinesOut(hostOut), .dataLinesOe(hostOe));
    pfwc_flash_model pfwc_flash_model_inst (
        .chipSelN(chipSelN), .outGateN(outGateN), .writeStrobeN(writeStrobeN), .addressLines(addressLines),
        .dataIn(dataLinesIn), .devOut(devOut), .devDrv(devDrv), .busy(flashBusy), .errs(modelErrs));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (failCount == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Output gate stays high during the write strobe to avoid bus contention
    always @(negedge clk) begin
        if (writeStrobeN === 1'b0) check("gate high in write", {outGateN, chipSelN}, 16'h0002);
        if (hostOe === 1'b1 && devDrv === 1'b1) check("bus contention", 16'h0001, 16'h0000);
    end
    task automatic do_op(pfwc_pkg::pfwc_op_t op, logic [15:0] adr, logic prot);
        int n;
        @(negedge clk);
        cmdOp = op;
        cmdAddr = adr;
        pageProtected = prot;
        cmdValid = 1'b1;
        for (n = 0; n < 200 && cmdReady !== 1'b1; n++) @(negedge clk);
        @(negedge clk);
        cmdValid = 1'b0;
        for (n = 0; n < 8000 && opDone !== 1'b1; n++) @(negedge clk);
        if (n == 8000) check("op done", 16'h0000, 16'h0001);
    endtask
    task automatic rd(logic [15:0] adr, logic [15:0] exp);
        do_op(pfwc_pkg::PFWC_OP_READ, adr, 1'b0);
        check("read data", rdData, exp);
        check("read valid", {15'h0000, rdValid}, 16'h0001);
    endtask
    task automatic page_poll(logic [15:0] base, logic prot, logic [15:0] pat);
        pagePat = pat;
        do_op(pfwc_pkg::PFWC_OP_PAGE, base, prot);
        if (flashBusy === 1'b1) begin
            do_op(pfwc_pkg::PFWC_OP_READ, base + 16'h007f, 1'b0);
            check("polled bits", rdData & 16'h8080, ~(pat ^ 16'h007f) & 16'h8080);
        end
        do_op(pfwc_pkg::PFWC_OP_POLL, base, 1'b0);
        check("device idle after poll", {14'h0000, pollBusy, flashBusy}, 16'h0000);
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        check("pins idle", {chipSelN, outGateN, writeStrobeN, hostOe}, 16'h000e);
        @(negedge clk);
        cmdOp = pfwc_pkg::PFWC_OP_PAGE;
        @(negedge clk);
        check("write ready early", {15'h0000, cmdReady}, 16'h0000);
        cmdOp = pfwc_pkg::PFWC_OP_READ;
        @(negedge clk);
        check("read ready early", {15'h0000, cmdReady}, 16'h0001);
        repeat (70) @(negedge clk);
    endtask
    task automatic t_shipped_protected();
        page_poll(16'h0100, 1'b0, 16'h5a00);
        rd(16'h0100, 16'hffff);
    endtask
    task automatic t_unprotect();
        do_op(pfwc_pkg::PFWC_OP_UNPROT, 16'h0000, 1'b0);
        page_poll(16'h8a00, 1'b0, 16'h3c00);
        rd(16'h8a00, 16'h3c00);
        rd(16'h8a7f, 16'h3c7f);
        rd(16'h8a80, 16'hffff);
    endtask
    task automatic t_protect();
        do_op(pfwc_pkg::PFWC_OP_PROTECT, 16'h0000, 1'b0);
        page_poll(16'h1200, 1'b0, 16'h7700);
        rd(16'h1200, 16'hffff);
        page_poll(16'h1200, 1'b1, 16'hc3a5);
        rd(16'h1200, 16'hc3a5);
        rd(16'h127f, 16'hc3da);
    endtask
    task automatic t_erase();
        do_op(pfwc_pkg::PFWC_OP_ERASE, 16'h0000, 1'b0);
        do_op(pfwc_pkg::PFWC_OP_POLL, 16'h0000, 1'b0);
        check("erase idle", {15'h0000, flashBusy}, 16'h0000);
        rd(16'h8a00, 16'hffff);
        rd(16'h1240, 16'hffff);
    endtask
    initial begin
        rst_n = 1'b0;
        cmdValid = 1'b0;
        cmdOp = pfwc_pkg::PFWC_OP_READ;
        cmdAddr = 16'h0000;
        pageProtected = 1'b0;
        pagePat = 16'h0000;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_shipped_protected();
        t_unprotect();
        t_protect();
        t_erase();
        check("model page errors", 16'(modelErrs), 16'h0000);
        give_verdict();
    end
    // Generous ceiling: four page loads of about 4500 cycles each plus polls
    initial begin
        repeat (60000) @(posedge clk);
        failCount++;
        give_verdict();
    end
endmodule // tb
